// file: hw/brc_card.sv
// Shared-bus RAM / erasable ROM card: decode, data drivers, write strobe,
// ready, indicator latch and switch data drivers.
// Assumes the bus pins are asynchronous to clk and phase-2 is far slower
// than clk; ROM images are loaded over the programming port beforehand.
//
// Operation
// - Active-low ready answers accepted write or read
// - Ready flop sets on phase-2 rise on request
// - Drive read word while drive enable active
// - Switch data uses separate wired-OR drivers
// - Active RAM write stores data bus word
// - ROM select decodes chip number one-of-sixteen
// - Sixteen chip slots; absent ones unpopulated
// - Eight-bit ROM word address common to chips
// - RAM 1024 words, address bits nine to zero
// - Write strobe pulses low within RAM select
// - Read keeps strobe high, word to drivers
// - Selected ROM presents word on common lines
// - Shared ROM address and drivers, own selects
// - Four banks of four, consecutive 256-word blocks
// - Processor or bus read both return word
// - Indicator register latches bus on output function
// - RAM range depends on extended memory option
// - ROM region when top four bits zero
// - Drive enable on read with valid select
// - Master reset clears write strobe and ready
`timescale 1ns/1ns
`default_nettype none

`include "brc_consts.svh"

module brc_card import brc_pkg::*; #(
	parameter int ROM_CHIPS = `BRC_ROM_CHIPS,
	parameter logic [`BRC_ROM_CHIPS-1:0] ROM_PRESENT = `BRC_CS_RST
) (
	// Clock and reset
	clk,
	rst,
	// Bus timing and control pins
	phi2,
	master_reset_n,
	cpu_mem_rd_n,
	bus_mem_rd_n,
	cpu_mem_wr_n,
	bus_mem_wr_n,
	out_strobe,
	in_strobe,
	ext_mem_n,
	// Address and data bus
	addr,
	data_in,
	mem_data_out,
	mem_data_oe,
	// Operator switch words and their drivers
	switch_words,
	sw_data_out,
	sw_data_oe,
	// Card status
	ready_n,
	ram_write_strobe_n,
	rom_cs_n,
	led_out,
	// ROM programming port
	prog_we,
	prog_addr,
	prog_data
);

	input wire logic clk;
	input wire logic rst;
	input wire logic phi2;
	input wire logic master_reset_n;
	input wire logic cpu_mem_rd_n;
	input wire logic bus_mem_rd_n;
	input wire logic cpu_mem_wr_n;
	input wire logic bus_mem_wr_n;
	input wire logic out_strobe;
	input wire logic in_strobe;
	input wire logic ext_mem_n;
	input wire logic [15:0] addr;
	input wire logic [7:0] data_in;
	output logic [7:0] mem_data_out;
	output logic mem_data_oe;
	input wire logic [3:0][7:0] switch_words;
	output logic [7:0] sw_data_out;
	output logic sw_data_oe;
	output logic ready_n;
	output logic ram_write_strobe_n;
	output logic [`BRC_ROM_CHIPS-1:0] rom_cs_n;
	output logic [7:0] led_out;
	input wire logic prog_we;
	input wire logic [`BRC_ROM_AW-1:0] prog_addr;
	input wire logic [7:0] prog_data;

	typedef struct packed {
		logic [BRC_PIN_W-1:0] s1;
		logic [BRC_PIN_W-1:0] s2;
		logic [BRC_PIN_W-1:0] s3;
		logic [BRC_PIN_W-1:0] filt;
		logic phi2_prev;
		brc_ws_t ws;
		logic write_strobe_n;
		logic ready_n;
		logic oe_d;
		logic ram_pick_d;
		logic rom_here_d;
		logic mem_oe;
		logic [7:0] mem_data;
		logic [7:0] led;
		logic [7:0] sw_data;
		logic sw_oe;
	} brc_card_st_t;

	brc_card_st_t r_reg;
	brc_card_st_t r_next;

	brc_pins_t raw;
	brc_pins_t p;
	logic phi2_rise;
	logic mrst;
	logic ram_sel;
	logic rom_sel;
	logic io_sel;
	logic rd_req;
	logic wr_req;
	logic wr_cond;
	logic rd_cond;
	logic ram_we;
	logic [7:0] ram_q;
	logic [7:0] rom_q;

	// ==========================================================
	// Pin capture
	always_comb begin
		raw = '0;
		raw.phi2 = phi2;
		raw.mrst_n = master_reset_n;
		raw.cpu_rd_n = cpu_mem_rd_n;
		raw.bus_rd_n = bus_mem_rd_n;
		raw.cpu_wr_n = cpu_mem_wr_n;
		raw.bus_wr_n = bus_mem_wr_n;
		raw.out_stb = out_strobe;
		raw.in_stb = in_strobe;
		raw.ext_mem_n = ext_mem_n;
		raw.addr = addr;
		raw.data = data_in;
		raw.sw = switch_words;
	end

	// ==========================================================
	// Decode of the filtered pins
	always_comb begin
		p = brc_pins_t'(r_reg.filt);
		phi2_rise = p.phi2 & ~r_reg.phi2_prev;
		mrst = ~p.mrst_n;
		// Extended option present: only the lower 1K lives here
		if (!p.ext_mem_n) begin
			ram_sel = (p.addr[15:10] == `BRC_RAM_TAG_EXT);
		end else begin
			ram_sel = (p.addr[15:11] == `BRC_RAM_TAG_BASIC);
		end
		rom_sel = (p.addr[15:12] == `BRC_ROM_TAG);
		io_sel = (p.addr[15:13] == `BRC_IO_CODE);
		rd_req = ~p.cpu_rd_n | ~p.bus_rd_n;
		wr_req = ~p.cpu_wr_n | ~p.bus_wr_n;
		wr_cond = wr_req & ram_sel;
		rd_cond = rd_req & (ram_sel | rom_sel);
		// Exactly one store per access, at the strobe's leading edge
		ram_we = phi2_rise & wr_cond & ~mrst & (r_reg.ws == BRC_WS_IDLE);
	end

	// ==========================================================
	// Next state
	always_comb begin
		r_next = r_reg;
		// Three-stage capture; a bit moves only when stages two and three agree
		r_next.s1 = raw;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		r_next.filt = (r_reg.s2 & ~(r_reg.s2 ^ r_reg.s3)) |
			(r_reg.filt & (r_reg.s2 ^ r_reg.s3));
		r_next.phi2_prev = p.phi2;

		// Write strobe and ready advance on phase-2 rising edges; master reset returns them to idle in any cycle
		if (mrst) begin
			r_next.ws = BRC_WS_IDLE;
			r_next.write_strobe_n = 1'b1;
			r_next.ready_n = 1'b1;
		end else if (phi2_rise) begin
			r_next.ready_n = ~(wr_cond | rd_cond);
			unique case (r_reg.ws)
				BRC_WS_IDLE: begin
					if (wr_cond) begin
						r_next.ws = BRC_WS_STROBE;
						r_next.write_strobe_n = 1'b0;
					end
				end
				BRC_WS_STROBE: begin
					r_next.write_strobe_n = 1'b1;
					r_next.ws = wr_cond ? BRC_WS_WAIT : BRC_WS_IDLE;
				end
				BRC_WS_WAIT: begin
					// A held write request must not strobe twice
					if (!wr_cond) begin
						r_next.ws = BRC_WS_IDLE;
					end
				end
			endcase
		end

		// Memory drivers, aligned to the registered memory read
		r_next.oe_d = rd_cond;
		r_next.ram_pick_d = ram_sel;
		r_next.rom_here_d = ROM_PRESENT[p.addr[`BRC_ROM_CHIP_HI:`BRC_ROM_CHIP_LO]];
		r_next.mem_oe = r_reg.oe_d;
		if (r_reg.ram_pick_d) begin
			r_next.mem_data = ram_q;
		end else if (r_reg.rom_here_d) begin
			r_next.mem_data = rom_q;
		end else begin
			r_next.mem_data = `BRC_ROM_BLANK;
		end

		// Indicator latch on the output function
		if (mrst) begin
			r_next.led = `BRC_DATA_RST;
		end else if (io_sel && p.out_stb) begin
			r_next.led = p.data;
		end

		// Switch words go out on their own drivers, never via memory drivers
		r_next.sw_oe = io_sel & p.in_stb;
		r_next.sw_data = p.sw[p.addr[`BRC_SW_SEL_HI:0]];
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			r_reg.s1 <= {BRC_PIN_W{`BRC_PINS_RST}};
			r_reg.s2 <= {BRC_PIN_W{`BRC_PINS_RST}};
			r_reg.s3 <= {BRC_PIN_W{`BRC_PINS_RST}};
			r_reg.filt <= {BRC_PIN_W{`BRC_PINS_RST}};
			r_reg.phi2_prev <= `BRC_PINS_RST;
			r_reg.ws <= BRC_WS_IDLE;
			r_reg.write_strobe_n <= 1'b1;
			r_reg.ready_n <= 1'b1;
			r_reg.oe_d <= 1'b0;
			r_reg.ram_pick_d <= 1'b0;
			r_reg.rom_here_d <= 1'b0;
			r_reg.mem_oe <= 1'b0;
			r_reg.mem_data <= `BRC_DATA_RST;
			r_reg.led <= `BRC_DATA_RST;
			r_reg.sw_data <= `BRC_DATA_RST;
			r_reg.sw_oe <= 1'b0;
		end else begin
			r_reg <= r_next;
		end
	end

	// ==========================================================
	// RAM, 1K words
	brc_mem #(
		.AW(`BRC_RAM_AW),
		.DW(8)
	) u_ram (
		.clk(clk),
		.we(ram_we),
		.waddr(p.addr[`BRC_RAM_AW-1:0]),
		.wdata(p.data),
		.raddr(p.addr[`BRC_RAM_AW-1:0]),
		.rdata(ram_q)
	);

	// ==========================================================
	// ROM, sixteen chips of 256 words in one array
	brc_mem #(
		.AW(`BRC_ROM_AW),
		.DW(8)
	) u_rom (
		.clk(clk),
		.we(prog_we),
		.waddr(prog_addr),
		.wdata(prog_data),
		.raddr(p.addr[`BRC_ROM_AW-1:0]),
		.rdata(rom_q)
	);

	// ==========================================================
	// Chip selects
	brc_dec #(
		.N(`BRC_ROM_CHIPS)
	) u_dec (
		.clk(clk),
		.rst(rst),
		.en_n(~rom_sel),
		.sel(p.addr[`BRC_ROM_CHIP_HI:`BRC_ROM_CHIP_LO]),
		.cs_n(rom_cs_n)
	);

	// ==========================================================
	// Outputs
	assign mem_data_out = r_reg.mem_data;
	assign mem_data_oe = r_reg.mem_oe;
	assign sw_data_out = r_reg.sw_data;
	assign sw_data_oe = r_reg.sw_oe;
	assign ready_n = r_reg.ready_n;
	assign ram_write_strobe_n = r_reg.write_strobe_n;
	assign led_out = r_reg.led;

endmodule // brc_card

`default_nettype wire

// file: pkg/brc_consts.svh
// Constants of the shared-bus RAM / erasable ROM card: address tags,
// field positions, reset values.
// Assumes inclusion by bare name; definitions only.
`ifndef BRC_CONSTS_SVH
`define BRC_CONSTS_SVH

// ==========================================================
// Address decode
`define BRC_RAM_TAG_EXT 6'h08
`define BRC_RAM_TAG_BASIC 5'h04
`define BRC_ROM_TAG 4'h0
`define BRC_IO_CODE 3'h6

// ==========================================================
// Field positions
`define BRC_RAM_AW 10
`define BRC_ROM_AW 12
`define BRC_ROM_CHIPS 16
`define BRC_ROM_CHIP_LO 8
`define BRC_ROM_CHIP_HI 11
`define BRC_SW_SEL_HI 1

// ==========================================================
// Reset values
`define BRC_DATA_RST 8'h00
`define BRC_CS_RST 16'hFFFF
`define BRC_ROM_BLANK 8'hFF
`define BRC_PINS_RST 1'b1

`endif

// file: pkg/brc_pkg.sv
// Types shared by the RAM / erasable ROM card design files.
// Assumes nothing of its surroundings.
package brc_pkg;

	// ==========================================================
	// Write strobe sequence
	typedef enum logic [2:0] {
		BRC_WS_IDLE = 3'b001,
		BRC_WS_STROBE = 3'b010,
		BRC_WS_WAIT = 3'b100
	} brc_ws_t;

	// ==========================================================
	// Bus pins as seen after synchronising
	typedef struct packed {
		logic phi2;
		logic mrst_n;
		logic cpu_rd_n;
		logic bus_rd_n;
		logic cpu_wr_n;
		logic bus_wr_n;
		logic out_stb;
		logic in_stb;
		logic ext_mem_n;
		logic [15:0] addr;
		logic [7:0] data;
		logic [3:0][7:0] sw;
	} brc_pins_t;

	localparam int BRC_PIN_W = $bits(brc_pins_t);

endpackage

// file: hw/brc_mem.sv
// Single-port-write, registered-read memory for the card RAM and ROM.
// Assumes write and read addresses come from the same clock domain.
`timescale 1ns/1ns
`default_nettype none

module brc_mem import brc_pkg::*; #(
	parameter int AW = 10,
	parameter int DW = 8
) (
	// Clock
	input wire logic clk,
	// Write side
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// Read side
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);

	typedef struct packed {
		logic [DW-1:0] q;
	} brc_mem_st_t;

	logic [DW-1:0] store [0:(1<<AW)-1];
	brc_mem_st_t r_reg;
	brc_mem_st_t r_next;

	// ==========================================================
	// Read register
	always_comb begin
		r_next = r_reg;
		r_next.q = store[raddr];
	end

	// Contents carry no reset, as on the real parts
	always_ff @(posedge clk) begin
		r_reg <= r_next;
		if (we) begin
			store[waddr] <= wdata;
		end
	end

	assign rdata = r_reg.q;

endmodule // brc_mem

`default_nettype wire

// file: hw/brc_dec.sv
// One-of-sixteen ROM chip select decoder, registered, active-low outputs.
// Assumes enable and select come from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

`include "brc_consts.svh"

module brc_dec import brc_pkg::*; #(
	parameter int N = `BRC_ROM_CHIPS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Decode inputs
	input wire logic en_n,
	input wire logic [$clog2(N)-1:0] sel,
	// Chip selects
	output logic [N-1:0] cs_n
);

	typedef struct packed {
		logic [N-1:0] cs_n;
	} brc_dec_st_t;

	brc_dec_st_t r_reg;
	brc_dec_st_t r_next;

	function automatic logic [N-1:0] one_low(input logic [$clog2(N)-1:0] s);
		logic [N-1:0] v;
		v = '1;
		v[s] = 1'b0;
		return v;
	endfunction

	// ==========================================================
	// Decode
	always_comb begin
		r_next = r_reg;
		r_next.cs_n = en_n ? '1 : one_low(sel);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r_reg <= '{cs_n: '1};
		end else begin
			r_reg <= r_next;
		end
	end

	assign cs_n = r_reg.cs_n;

endmodule // brc_dec

`default_nettype wire

// file: test/brc_card_assertions.sv
// Concurrent checks on the pins of the RAM / ROM card.
// Assumes the bench holds address and data steady during an access.
`timescale 1ns/1ns
`default_nettype none

module brc_card_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus pins
	input wire logic phi2,
	input wire logic master_reset_n,
	input wire logic cpu_mem_rd_n,
	input wire logic ext_mem_n,
	input wire logic out_strobe,
	input wire logic in_strobe,
	input wire logic [15:0] addr,
	input wire logic [7:0] data_in,
	input wire logic [3:0][7:0] switch_words,
	// Card outputs
	input wire logic mem_data_oe,
	input wire logic [7:0] sw_data_out,
	input wire logic sw_data_oe,
	input wire logic ready_n,
	input wire logic ram_write_strobe_n,
	input wire logic [15:0] rom_cs_n,
	input wire logic [7:0] led_out
);
	logic rom_hit, ram_hit, io_hit;
	assign rom_hit = addr[15:12] == 4'h0;
	assign ram_hit = addr[15:10] == 6'h08 || (ext_mem_n && addr[15:11] == 5'h04);
	assign io_hit = addr[15:13] == 3'h6;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// Decode and drivers
	cs_onehot_a: assert property ($onehot0(~rom_cs_n))
		else $error("two ROM selects low");
	cs_decode_a: assert property (($stable(addr) && rom_hit)[*8] |-> !rom_cs_n[addr[11:8]])
		else $error("ROM select not decoded");
	cs_idle_a: assert property ((!rom_hit)[*8] |-> rom_cs_n == 16'hFFFF)
		else $error("ROM select outside region");
	oe_idle_a: assert property ((!rom_hit && !ram_hit)[*8] |-> !mem_data_oe)
		else $error("bus driven outside regions");
	oe_read_a: assert property ((ram_hit && !cpu_mem_rd_n && $stable(addr))[*8] |-> mem_data_oe)
		else $error("read word not driven");
	sw_drive_a: assert property ((io_hit && in_strobe && $stable(addr))[*8]
		|-> sw_data_oe && sw_data_out == switch_words[addr[1:0]])
		else $error("switch word wrong");
	led_latch_a: assert property (
		(io_hit && out_strobe && master_reset_n && $stable(data_in))[*8]
		|-> led_out == data_in)
		else $error("indicator not latched");

	// ==========================================================
	// Ready and strobe
	strobe_ready_a: assert property (!ram_write_strobe_n |-> !ready_n)
		else $error("strobe without ready");
	ready_set_a: assert property (disable iff (rst || !master_reset_n)
		$fell(ready_n) |-> $past(phi2, 2))
		else $error("ready set off phase two");
	ready_clr_a: assert property (disable iff (rst || !master_reset_n)
		$rose(ready_n) |-> $past(phi2, 2))
		else $error("ready cleared off phase two");
	mrst_clear_a: assert property ((!master_reset_n)[*5]
		|=> ready_n && ram_write_strobe_n && led_out == 8'h00)
		else $error("master reset did not clear");

	cover property (!ram_write_strobe_n);
	cover property ($fell(ready_n) && mem_data_oe);
	cover property (!rom_cs_n[15]);
endmodule // brc_card_chk

bind brc_card brc_card_chk u_chk (.clk, .rst, .phi2, .master_reset_n, .cpu_mem_rd_n,
	.ext_mem_n, .out_strobe, .in_strobe, .addr, .data_in, .switch_words, .mem_data_oe,
	.sw_data_out, .sw_data_oe, .ready_n, .ram_write_strobe_n, .rom_cs_n, .led_out);

`default_nettype wire

// file: test/brc_bus_partner.sv
// Far side of the card: phase-2 clock and the shared data bus.
// Assumes one clk domain; phase two is high for 12 of every 24 clk periods.
`timescale 1ns/1ns
`default_nettype none

module brc_bus_partner (
	// Clock
	input wire logic clk,
	// Phase-2 clock
	output logic phi2,
	// Master write drivers
	input wire logic drv_en,
	input wire logic [7:0] drv_data,
	// Card drivers
	input wire logic mem_oe,
	input wire logic [7:0] mem_data,
	input wire logic sw_oe,
	input wire logic [7:0] sw_data,
	// Resolved bus
	output logic [7:0] bus
);
	logic [4:0] cnt = 5'h00;
	logic [7:0] last = 8'h00;
	initial phi2 = 1'b0;
	always @(posedge clk) begin
		cnt <= (cnt == 5'h17) ? 5'h00 : cnt + 5'h01;
		phi2 <= cnt >= 5'h0C;
		if (drv_en || mem_oe || sw_oe) begin
			last <= bus;
		end
	end
	// Released bus shows the inverse of the last driven word, never a stale copy
	assign bus = drv_en ? drv_data :
		(mem_oe || sw_oe) ? ((mem_oe ? mem_data : 8'h00) | (sw_oe ? sw_data : 8'h00)) : ~last;
endmodule // brc_bus_partner

`default_nettype wire

// file: test/shared_bus_ram_eprom_card_bench.sv
// Self-checking bench for the RAM / ROM card.
// Assumes the partner makes phase two and resolves the data bus.
`timescale 1ns/1ns
`default_nettype none

module shared_bus_ram_eprom_card_bench;
	logic clk = 1'b0, rst = 1'b1, phi2, master_reset_n = 1'b1, ext_mem_n = 1'b0;
	logic cpu_mem_rd_n = 1'b1, bus_mem_rd_n = 1'b1, cpu_mem_wr_n = 1'b1, bus_mem_wr_n = 1'b1;
	logic out_strobe = 1'b0, in_strobe = 1'b0, drv_en = 1'b0, prog_we = 1'b0;
	logic mem_data_oe, sw_data_oe, ready_n, ram_write_strobe_n;
	logic [15:0] addr = 16'hFFFF, rom_cs_n;
	logic [11:0] prog_addr = 12'h000;
	logic [7:0] data_in, drv_data = 8'h00, prog_data = 8'h00, mem_data_out, sw_data_out, led_out, q;
	logic [3:0][7:0] switch_words = {8'h96, 8'h69, 8'h0F, 8'hF0};
	int error_cnt = 0, tests_run = 0, cyc = 0;

	always #2 clk = ~clk;

	brc_card #(.ROM_PRESENT(16'h7FFF)) dut (.clk, .rst, .phi2, .master_reset_n, .cpu_mem_rd_n,
		.bus_mem_rd_n, .cpu_mem_wr_n, .bus_mem_wr_n, .out_strobe, .in_strobe, .ext_mem_n,
		.addr, .data_in, .mem_data_out, .mem_data_oe, .switch_words, .sw_data_out, .sw_data_oe,
		.ready_n, .ram_write_strobe_n, .rom_cs_n, .led_out, .prog_we, .prog_addr, .prog_data);
	brc_bus_partner u_bus (.clk, .phi2, .drv_en, .drv_data, .mem_oe(mem_data_oe),
		.mem_data(mem_data_out), .sw_oe(sw_data_oe), .sw_data(sw_data_out), .bus(data_in));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Kind k: 0 processor read, 1 bus read, 2 bus write
	task automatic acc(input logic [15:0] a, input int k, input logic [7:0] d,
		input logic rdy, input logic ext);
		int n;
		n = 0;
		@(negedge phi2);
		@(posedge clk);
		addr <= a;
		ext_mem_n <= ext;
		drv_en <= k == 2;
		drv_data <= d;
		cpu_mem_rd_n <= k != 0;
		bus_mem_rd_n <= k != 1;
		bus_mem_wr_n <= k != 2;
		while (ready_n !== 1'b0 && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk(n < 60, rdy);
		if (k == 2 && rdy) chk(ram_write_strobe_n, 1'b0);
		if (k < 2 && rdy) chk(mem_data_oe, 1'b1);
		if (k < 2) chk(ram_write_strobe_n, 1'b1);
		q = mem_data_out;
		@(posedge clk);
		{cpu_mem_rd_n, bus_mem_rd_n, bus_mem_wr_n} <= 3'h7;
		drv_en <= 1'b0;
		n = 0;
		while (ready_n !== 1'b1 && n < 60) begin
			@(negedge clk);
			n++;
		end
		chk(ready_n, 1'b1);
	endtask

	task automatic t_ram();
		acc(16'h23FF, 2, 8'hA5, 1'b1, 1'b0);
		acc(16'h2000, 2, 8'h3C, 1'b1, 1'b0);
		acc(16'h23FF, 0, 8'h00, 1'b1, 1'b0);
		chk(q, 8'hA5);
		acc(16'h2000, 1, 8'h00, 1'b1, 1'b0);
		chk(q, 8'h3C);
	endtask

	task automatic t_alias();
		acc(16'h27FF, 1, 8'h00, 1'b1, 1'b1);
		chk(q, 8'hA5);
		acc(16'h27FF, 0, 8'h00, 1'b0, 1'b0);
		acc(16'h0100, 2, 8'h77, 1'b0, 1'b0);
	endtask

	task automatic t_rom();
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			prog_we <= 1'b1;
			prog_addr <= {i[3:0], ~i[3:0], i[3:0]};
			prog_data <= {i[3:0], 4'hC};
		end
		@(posedge clk);
		prog_we <= 1'b0;
		for (int i = 0; i < 16; i++) begin
			acc({4'h0, i[3:0], ~i[3:0], i[3:0]}, i % 2, 8'h00, 1'b1, 1'b0);
			chk(q, i == 15 ? 8'hFF : {i[3:0], 4'hC});
			chk(rom_cs_n, ~(16'h0001 << i));
		end
	endtask

	task automatic t_io();
		@(posedge clk);
		addr <= 16'hC003;
		in_strobe <= 1'b1;
		// Long enough for the eight-cycle switch check to see a settled address
		repeat (10) @(posedge clk);
		chk({sw_data_oe, sw_data_out}, {1'b1, 8'h96});
		in_strobe <= 1'b0;
		drv_en <= 1'b1;
		drv_data <= 8'h5A;
		out_strobe <= 1'b1;
		repeat (10) @(posedge clk);
		out_strobe <= 1'b0;
		drv_en <= 1'b0;
		repeat (4) @(posedge clk);
		chk(led_out, 8'h5A);
	endtask

	// Master reset lands in the middle of a held write
	task automatic t_mrst();
		@(negedge phi2);
		@(posedge clk);
		addr <= 16'h2001;
		drv_en <= 1'b1;
		cpu_mem_wr_n <= 1'b0;
		repeat (20) @(posedge clk);
		chk(ram_write_strobe_n, 1'b0);
		master_reset_n <= 1'b0;
		repeat (6) @(posedge clk);
		chk({ready_n, ram_write_strobe_n, led_out}, {2'b11, 8'h00});
		master_reset_n <= 1'b1;
		cpu_mem_wr_n <= 1'b1;
		drv_en <= 1'b0;
	endtask

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		t_ram();
		t_alias();
		t_rom();
		t_io();
		t_mrst();
		end_sim();
	end
endmodule // shared_bus_ram_eprom_card_bench

`default_nettype wire
